// *** verilog/hrsb_bridge.v ***
// Purpose: two-wire slave port onto four input and four output report bytes
// Assumes: bus clock is oversampled by ref_clk; host side is a byte strobe
// Notes:   serial clock and data are sampled, never used as clocks
// Overview of operation
// - Slave only, up to fast-mode rate
// - Answer only address 0111000
// - First write byte selects register 0-3
// - Data write to 0-3 sends four-byte report
// - Report order: bytes 0,1,2,3
// - Resend on buttons or data, 2 ms poll
// - Host output report stored in register
// - Data changes only while clock low
// - Acknowledge each byte, low means yes
// - Eighth address bit gives direction
// - Acknowledge address byte by pulling low
// - Write stores bytes, address auto-increments
// - Read returns current, then next registers
// - Low four button bits not writable
// - Ring bit write plays one sequence
// - 0-3 input report, 4-7 output report
`include "hrsb_map.vh"
module hrsb_bridge #(
  parameter POLL_CYC = `HRSB_POLL_CYC,   // Host poll interval in cycles
  parameter RING_CYC = `HRSB_RING_CYC    // Length of one ringing sequence
) (
  input  wire        ref_clk,       // 50 MHz core clock
  input  wire        rst_n,         // Sync reset, active low
  input  wire        serial_clk_i,  // Bus clock pin from master
  input  wire        serial_data_i, // Data pin level
  output reg         serial_data_o, // Data drive value, always 0
  output reg         serial_data_oe,// High while pulling data low
  input  wire [3:0]  button_i,      // Button levels, same clock
  input  wire        host_wr_i,     // Host output report byte strobe
  input  wire [1:0]  host_idx_i,    // Which output byte
  input  wire [7:0]  host_data_i,   // Output report byte
  output reg         rpt_valid,     // Report new at the latest poll
  output reg  [31:0] rpt_data,      // Report, byte 0 in low bits
  output reg         host_poll,     // One-cycle poll pulse
  output reg         mcu_int,       // New output report pending
  output reg         ring_on        // Buzzer sequence running
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_AACK = 3'h2;
  localparam ST_WRX  = 3'h3;
  localparam ST_WACK = 3'h4;
  localparam ST_RTX  = 3'h5;
  localparam ST_RACK = 3'h6;

  wire scl_s;
  wire sda_s;
  reg  scl_d_r;
  reg  sda_d_r;
  reg  [2:0]  st_r;
  reg  [3:0]  bit_r;
  reg  [7:0]  sh_r;
  reg  [2:0]  ptr_r;
  reg         first_r;
  reg  [7:0]  regs_r [0:7];
  reg         dirty_r;
  reg  [3:0]  btn_d_r;
  reg  [31:0] poll_r;
  reg  [31:0] ring_r;
  integer     i;

  // Slave only; 50 MHz oversamples fast mode
  hrsb_sync u_scl (.ref_clk(ref_clk), .rst_n(rst_n), .d_in(serial_clk_i), .q_out(scl_s));
  hrsb_sync u_sda (.ref_clk(ref_clk), .rst_n(rst_n), .d_in(serial_data_i), .q_out(sda_s));

  wire scl_rise = scl_s & ~scl_d_r;
  wire scl_fall = ~scl_s & scl_d_r;
  // Data edge while clock high frames
  wire start_c  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_c   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire [7:0] rx_byte = {sh_r[6:0], sda_s};
  wire       btn_chg = (button_i != btn_d_r);
  // Poll edge; snapshot and dirty clear share it so a same-cycle set is not lost
  wire       poll_hit = (poll_r >= POLL_CYC - 1);

  // Edge history of the synchronised pins
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // Bus engine, register file and host side; bus write wins over host strobe for register bytes
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r           <= ST_IDLE;
      bit_r          <= 4'h0;
      sh_r           <= 8'h00;
      ptr_r          <= 3'h0;
      first_r        <= 1'b0;
      serial_data_o  <= 1'b0;
      serial_data_oe <= 1'b0;
      dirty_r        <= 1'b0;
      mcu_int        <= 1'b0;
      ring_r         <= 32'h0;
      for (i = 0; i < 8; i = i + 1)
        regs_r[i] <= 8'h00;
    end else begin
      serial_data_o <= 1'b0;
      if (ring_r != 32'h0)
        ring_r <= ring_r - 32'h1;
      regs_r[0] <= {regs_r[0][7:4], button_i};
      // Buttons mark report; a set beats the poll-edge clear
      if (btn_chg)
        dirty_r <= 1'b1;
      else if (poll_hit)
        dirty_r <= 1'b0;
      if (host_wr_i) begin
        regs_r[`HRSB_OUT_BASE + {1'b0, host_idx_i}] <= host_data_i;
        mcu_int <= 1'b1;
        // Host ring bit also starts one sequence
        if (host_idx_i == 2'h0 && host_data_i[`HRSB_RING_BIT])
          ring_r <= RING_CYC;
      end
      if (start_c) begin
        st_r           <= ST_ADDR;
        bit_r          <= 4'h0;
        serial_data_oe <= 1'b0;
      end else if (stop_c) begin
        st_r           <= ST_IDLE;
        serial_data_oe <= 1'b0;
      end else begin
        case (st_r)
          ST_IDLE: begin
            serial_data_oe <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              sh_r  <= rx_byte;
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              if (sh_r[7:1] == `HRSB_SLAVE_ADDR) begin
                serial_data_oe <= 1'b1;
                st_r           <= ST_AACK;
              end else
                st_r <= ST_IDLE;
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              bit_r <= 4'h0;
              if (sh_r[0]) begin
                sh_r           <= regs_r[ptr_r];
                serial_data_oe <= ~regs_r[ptr_r][7];
                st_r           <= ST_RTX;
              end else begin
                serial_data_oe <= 1'b0;
                first_r        <= 1'b1;
                st_r           <= ST_WRX;
              end
            end
          end
          ST_WRX: begin
            if (scl_rise) begin
              sh_r  <= rx_byte;
              bit_r <= bit_r + 4'h1;
            end else if (scl_fall && bit_r == 4'h8) begin
              serial_data_oe <= 1'b1;
              st_r           <= ST_WACK;
              if (first_r) begin
                ptr_r   <= {1'b0, sh_r[1:0]};
                first_r <= 1'b0;
              end else begin
                ptr_r <= ptr_r + 3'h1;
                if (ptr_r == 3'h0)
                  regs_r[0] <= {sh_r[7:4], button_i};
                else
                  regs_r[ptr_r] <= sh_r;
                if (ptr_r < `HRSB_OUT_BASE)
                  dirty_r <= 1'b1;
                // Bus write of register four clears; a host write in the same cycle wins
                if (ptr_r == `HRSB_OUT_BASE && !host_wr_i)
                  mcu_int <= 1'b0;
                if (ptr_r == `HRSB_OUT_BASE && sh_r[`HRSB_RING_BIT])
                  ring_r <= RING_CYC;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              serial_data_oe <= 1'b0;
              bit_r          <= 4'h0;
              st_r           <= ST_WRX;
            end
          end
          ST_RTX: begin
            if (scl_fall) begin
              if (bit_r == 4'h7) begin
                serial_data_oe <= 1'b0;
                st_r           <= ST_RACK;
              end else begin
                serial_data_oe <= ~sh_r[6];
                sh_r           <= {sh_r[6:0], 1'b0};
              end
              bit_r <= bit_r + 4'h1;
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              if (sda_s)
                st_r <= ST_IDLE;
              else
                ptr_r <= ptr_r + 3'h1;
            end else if (scl_fall) begin
              bit_r          <= 4'h0;
              sh_r           <= regs_r[ptr_r];
              serial_data_oe <= ~regs_r[ptr_r][7];
              st_r           <= ST_RTX;
            end
          end
          default: begin
            st_r           <= ST_IDLE;
            serial_data_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // Poll timer and report snapshot every interval
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      poll_r    <= 32'h0;
      host_poll <= 1'b0;
      rpt_valid <= 1'b0;
      rpt_data  <= 32'h0;
      btn_d_r   <= 4'h0;
      ring_on   <= 1'b0;
    end else begin
      btn_d_r   <= button_i;
      ring_on   <= (ring_r != 32'h0);
      host_poll <= 1'b0;
      if (poll_hit) begin
        poll_r    <= 32'h0;
        host_poll <= 1'b1;
        rpt_valid <= dirty_r;
        rpt_data  <= {regs_r[3], regs_r[2], regs_r[1], regs_r[0]};
      end else
        poll_r <= poll_r + 32'h1;
    end
  end
endmodule // hrsb_bridge

// *** verilog/hrsb_map.vh ***
// Purpose: constants for the report serial slave bridge
// Assumes: 50 MHz core clock
// Notes:   register indices are the 3-bit internal addresses
`ifndef HRSB_MAP_VH
`define HRSB_MAP_VH
`define HRSB_SLAVE_ADDR     7'h38
`define HRSB_IN_BASE        3'h0
`define HRSB_OUT_BASE       3'h4
`define HRSB_BTN_MASK       8'h0f
`define HRSB_RING_BIT       5
`define HRSB_POLL_US        2000
`define HRSB_CLK_MHZ        50
`define HRSB_POLL_CYC       (`HRSB_POLL_US * `HRSB_CLK_MHZ)
`define HRSB_RING_CYC       32'h0000c350
`endif

// *** verilog/hrsb_sync.v ***
// Purpose: two-flop synchroniser for one level
// Assumes: input is from another domain
// Notes:   first flop feeds only the second
module hrsb_sync (
  input  wire ref_clk,   // Core clock
  input  wire rst_n,     // Sync reset, active low
  input  wire d_in,      // Async level
  output reg  q_out      // Synchronised level
);
  reg meta_r;
  // Two stages, reset to idle-high bus level
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      q_out  <= 1'b1;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule // hrsb_sync

// *** test/hrsb_bridge_sva.sv ***
// Purpose: Port checks for the report bridge
// Assumes: One clock domain, sync reset
// Notes:   Ring length is counted in helper logic
module hrsb_bridge_sva #(
  parameter RING_CYC = 50000  // Ring sequence length
) (
  input logic        ref_clk,        // Core clock
  input logic        rst_n,          // Reset, active low
  input logic        serial_clk_i,   // Bus clock pin
  input logic        serial_data_i,  // Data pin level
  input logic        serial_data_o,  // Drive value
  input logic        serial_data_oe, // Pull-low enable
  input logic        host_wr_i,      // Host byte strobe
  input logic        rpt_valid,      // Report flag
  input logic [31:0] rpt_data,       // Report bytes
  input logic        host_poll,      // Poll pulse
  input logic        mcu_int,        // Pending flag
  input logic        ring_on         // Buzzer running
);
  int unsigned rc_r;
  int unsigned sf_r;
  logic        scl_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Cycles of ringing so far; zero outside a sequence
  always @(posedge ref_clk) rc_r <= (!rst_n || !ring_on) ? 0 : rc_r + 1;
  // Bus clock falls while data is pulled low; independent of bit rate, unlike a cycle bound
  always @(posedge ref_clk) scl_q <= serial_clk_i;
  always @(posedge ref_clk) sf_r <= (!rst_n || !serial_data_oe) ? 0 : sf_r + (scl_q && !serial_clk_i);
  sequence s_ring_end; $fell(ring_on); endsequence
  property p_ring_len; s_ring_end |-> rc_r == RING_CYC; endproperty
  property p_ring_cap; ring_on |-> rc_r < RING_CYC; endproperty
  property p_poll; host_poll |=> !host_poll; endproperty
  property p_rpt; $changed(rpt_data) |-> host_poll; endproperty
  property p_valid; $changed(rpt_valid) |-> host_poll; endproperty
  property p_od; serial_data_oe |-> !serial_data_o; endproperty
  property p_oe_scl; $changed(serial_data_oe) |-> !serial_clk_i; endproperty
  property p_oe_rel; serial_data_oe |-> sf_r <= 9; endproperty
  property p_int; host_wr_i |=> mcu_int; endproperty
  a_ring_len: assert property (p_ring_len) else $error("ring length");
  a_ring_cap: assert property (p_ring_cap) else $error("ring too long");
  a_poll: assert property (p_poll) else $error("poll pulse");
  a_rpt: assert property (p_rpt) else $error("report off poll");
  a_valid: assert property (p_valid) else $error("valid off poll");
  a_od: assert property (p_od) else $error("data not open drain");
  a_oe_scl: assert property (p_oe_scl) else $error("data moved, clock high");
  a_oe_rel: assert property (p_oe_rel) else $error("data held low");
  a_int: assert property (p_int) else $error("int not set");
endmodule // hrsb_bridge_sva
bind hrsb_bridge hrsb_bridge_sva #(.RING_CYC(RING_CYC)) u_sva (.ref_clk(ref_clk), .rst_n(rst_n),
  .serial_clk_i(serial_clk_i), .serial_data_i(serial_data_i), .serial_data_o(serial_data_o),
  .serial_data_oe(serial_data_oe),
  .host_wr_i(host_wr_i), .rpt_valid(rpt_valid), .rpt_data(rpt_data), .host_poll(host_poll),
  .mcu_int(mcu_int), .ring_on(ring_on));

// *** test/hrsb_mcu_model.sv ***
// Purpose: Two-wire bus master standing in for the microcontroller
// Assumes: Pull-up on data; 160 ns bit, clock low 100 ns
// Notes:   Clock stands high between frames
module hrsb_mcu_model (
  output logic scl,     // Bus clock, always ours
  output logic sda_oe,  // High pulls data low
  input  logic sda      // Resolved data level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // Change while low; 20 ns hold avoids a false frame edge
  task automatic bit_io(input logic b, output logic r);
    #20 sda_oe = !b;
    #80 scl = 1'b1;
    #50 r = sda;
    #10 scl = 1'b0;
  endtask
  task automatic start;
    #20 sda_oe = 1'b0;
    #80 scl = 1'b1;
    #40 sda_oe = 1'b1;
    #40 scl = 1'b0;
  endtask
  task automatic stop;
    #20 sda_oe = 1'b1;
    #80 scl = 1'b1;
    #40 sda_oe = 1'b0;
    #40;
  endtask
  // Byte out, ack bit returned raw
  task automatic wr(input logic [7:0] d, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, a);
  endtask
  // Byte in, nak ends a read
  task automatic rd(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nak, r);
  endtask
endmodule // hrsb_mcu_model

// *** test/tb_hid_report_serial_slave_bridge.sv ***
// Purpose: Self-checking bench for the report bridge
// Assumes: Short poll and ring counts
// Notes:   Inputs change 2 ns after the edge
module tb_hid_report_serial_slave_bridge;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 0, rst_n = 0, hw = 0, m_oe, scl, d_oe, d_o, pv, hp, mi, ro;
  logic [3:0] btn = 4'h0;
  logic [1:0] hi = 2'h0;
  logic [7:0] hd = 8'h00, d;
  logic [31:0] rd_w;
  logic a;
  int error_cnt = 0, n_compared = 0, k;
  logic [31:0] rw [2] = '{32'ha5c3_96f0, 32'h0f1e_2d3f};
  logic [3:0] bt [2] = '{4'h5, 4'ha};
  wire sda = !(d_oe || m_oe);
  always #10 ref_clk = ~ref_clk;
  hrsb_bridge #(.POLL_CYC(200), .RING_CYC(40)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .serial_clk_i(scl),
    .serial_data_i(sda), .serial_data_o(d_o), .serial_data_oe(d_oe), .button_i(btn), .host_wr_i(hw),
    .host_idx_i(hi), .host_data_i(hd), .rpt_valid(pv), .rpt_data(rd_w), .host_poll(hp), .mcu_int(mi),
    .ring_on(ro));
  hrsb_mcu_model u_mst (.scl(scl), .sda_oe(m_oe), .sda(sda));
  task stop_test;
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  // Bounded wait for the next poll pulse
  task wpoll;
    int i;
    for (i = 0; i < 400 && hp !== 1'b1; i++) cyc(1);
    if (hp !== 1'b1) begin
      error_cnt++;
      stop_test;
    end
    cyc(1);
  endtask
  // Write frame of n bytes, each acked; stop left off for a repeated start
  task wtx(input logic [7:0] b [6], input int n, input logic stp);
    u_mst.start;
    for (int i = 0; i < n; i++) begin
      u_mst.wr(b[i], a);
      chk("ack", 0, a);
    end
    if (stp) u_mst.stop;
  endtask
  initial begin
    #1_500_000 error_cnt++;
    stop_test;
  end
  initial begin
    cyc(20);
    rst_n = 1;
    cyc(4);
    // Row loop: buttons and four bytes from register zero
    for (k = 0; k < 2; k++) begin
      btn = bt[k];
      wtx('{8'h70, 8'h00, rw[k][7:0], rw[k][15:8], rw[k][23:16], rw[k][31:24]}, 6, 1);
      wpoll;
      chk("rpt_data", {rw[k][31:4], bt[k]}, rd_w);
      wpoll;
      chk("rpt_valid", 0, pv);
      btn = ~bt[k];
      wpoll;
      chk("rpt_valid", 1, pv);
    end
    for (k = 0; k < 4; k++) begin
      hw = 1;
      hi = k[1:0];
      hd = 8'h90 | k[7:0];
      cyc(1);
    end
    hw = 0;
    cyc(1);
    chk("mcu_int", 1, mi);
    // Pointer set, repeated start, seven reads with nak last
    wtx('{8'h70, 8'h01, 0, 0, 0, 0}, 2, 0);
    wtx('{8'h71, 0, 0, 0, 0, 0}, 1, 0);
    for (k = 1; k < 8; k++) begin
      u_mst.rd(k == 7, d);
      chk("rd", k < 4 ? rw[1] >> (8 * k) & 8'hff : 8'h90 | (k - 4), d);
    end
    u_mst.stop;
    // Foreign address is refused
    u_mst.start;
    u_mst.wr(8'h72, a);
    chk("nack", 1, a);
    u_mst.stop;
    // Ring trigger through auto-increment into register four
    wtx('{8'h70, 8'h03, rw[1][31:24], 8'h20, 0, 0}, 4, 1);
    chk("ring_on", 1, ro);
    chk("mcu_int", 0, mi);
    cyc(40);
    chk("ring_on", 0, ro);
    // Host output byte zero with the ring bit plays one sequence too
    hw = 1;
    hi = 2'h0;
    hd = 8'h20;
    cyc(1);
    hw = 0;
    cyc(1);
    chk("ring_on", 1, ro);
    chk("mcu_int", 1, mi);
    cyc(40);
    chk("ring_on", 0, ro);
    rst_n = 0;
    cyc(2);
    chk("rst", 0, {pv, mi, ro, d_oe, rd_w[27:0]});
    rst_n = 1;
    cyc(2);
    stop_test;
  end
endmodule // tb_hid_report_serial_slave_bridge
